/* File: pkg/btc_pkg.sv */
package btc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int BTC_NUM_RATES = 27;
  localparam int BTC_NUM_CT = 2;
  localparam int BTC_NUM_PRD = 2;
  localparam int BTC_SEL_W = 5;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] BTC_CT_BASE = 8'h00;
  localparam logic [7:0] BTC_PRD_BASE = 8'h20;
  localparam logic [7:0] BTC_UNIT_STRIDE = 8'h10;
  localparam logic [7:0] BTC_OFS_LO = 8'h00;
  localparam logic [7:0] BTC_OFS_HI = 8'h04;
  localparam logic [7:0] BTC_OFS_CTL = 8'h08;
  localparam logic [7:0] BTC_CSEL_BASE = 8'h40;
  localparam logic [7:0] BTC_CSEL_STRIDE = 8'h04;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int BTC_SRC_LSB = 0;
  localparam int BTC_MODE_LSB = 3;
  localparam int BTC_CT_RUN_BIT = 5;
  localparam int BTC_CT_DONE_BIT = 6;
  localparam int BTC_PRD_RUN_BIT = 3;
  localparam logic [15:0] BTC_PRESET_RST = 16'h0001;
  localparam logic [2:0] BTC_SRC_RST = 3'h0;

  // ---------------------------------------------------------------
  // Clock select codes: 0..26 pick a fixed rate
  // ---------------------------------------------------------------
  localparam logic [4:0] BTC_SEL_CT0 = 5'h1b;
  localparam logic [4:0] BTC_SEL_OFF = 5'h1f;
  localparam logic [3:0] BTC_MID_PHASE = 4'h7;
  localparam logic [3:0] BTC_LAST_PHASE = 4'hf;

  typedef enum logic [1:0] {
    BTC_MODE_CHAR,
    BTC_MODE_COUNTER,
    BTC_MODE_TIMER,
    BTC_MODE_TIMEOUT
  } btc_mode_t;

  typedef struct packed {
    logic x16;
    logic mid;
    logic bit_end;
  } btc_sclk_t;

  // Reference cycles per 16x period, fastest rate first
  function automatic logic [14:0] btc_rate_period(input int idx);
    case (idx)
      0: return 15'h0001;  1: return 15'h0002;  2: return 15'h0004;
      3: return 15'h0008;  4: return 15'h0010;  5: return 15'h0018;
      6: return 15'h0020;  7: return 15'h0030;  8: return 15'h0040;
      9: return 15'h0060;  10: return 15'h0080; 11: return 15'h00c0;
      12: return 15'h0100; 13: return 15'h0180; 14: return 15'h01cd;
      15: return 15'h0200; 16: return 15'h0300; 17: return 15'h0400;
      18: return 15'h0600; 19: return 15'h0800; 20: return 15'h0c00;
      21: return 15'h1200; 22: return 15'h1800; 23: return 15'h1ac4;
      24: return 15'h20ba; 25: return 15'h3000; default: return 15'h4800;
    endcase
  endfunction

endpackage

/* File: src/btc_clock_gen.sv */
`timescale 1ns/1ns
module btc_clock_gen
  import btc_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [BTC_NUM_CT-1:0] rx_char_i,
  output logic [BTC_NUM_RATES-1:0] fixed_rate_x16_o,
  output logic [BTC_NUM_CT-1:0] gp_ct_o,
  output logic [BTC_NUM_PRD-1:0] gp_prd_o,
  output btc_sclk_t [NUM_CH-1:0] rx_sclk_o,
  output btc_sclk_t [NUM_CH-1:0] tx_sclk_o
);

  if (NUM_CH < 1 || NUM_CH > 4) begin : g_chk
    $error("NUM_CH must be 1 to 4");
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  // Source k ticks once every 2**k reference cycles
  function automatic logic src_tick(input logic [6:0] pre,
                                    input logic [2:0] sel);
    logic [7:0] t;
    t[0] = 1'b1;
    for (int k = 1; k < 8; k++) begin
      t[k] = ((pre & (7'h7f >> (7 - k))) == (7'h7f >> (7 - k)));
    end
    return t[sel];
  endfunction

  function automatic logic [7:0] unit_adr(input logic [7:0] base,
                                          input int idx,
                                          input logic [7:0] ofs);
    return base + 8'(idx) * BTC_UNIT_STRIDE + ofs;
  endfunction

  logic [6:0] pre_reg;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_next;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 7'h00;
    end else begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // Fixed rate generator
  // ---------------------------------------------------------------
  // Periods are in reference cycles, so rates follow the reference
  for (genvar r = 0; r < BTC_NUM_RATES; r++) begin : g_rate
    localparam logic [14:0] PER = btc_rate_period(r);
    logic [14:0] cnt_reg;
    always_ff @(posedge clk_i) begin
      if (rst_i || cnt_reg == PER - 15'h0001) begin
        cnt_reg <= 15'h0000;
      end else begin
        cnt_reg <= cnt_reg + 15'h0001;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        fixed_rate_x16_o[r] <= 1'b0;
      end else begin
        fixed_rate_x16_o[r] <= (cnt_reg == PER - 15'h0001);
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter/timers
  // ---------------------------------------------------------------
  logic [15:0] ct_preset_reg [BTC_NUM_CT];
  logic [15:0] ct_cnt_reg [BTC_NUM_CT];
  logic [2:0] ct_src_reg [BTC_NUM_CT];
  btc_mode_t ct_mode_reg [BTC_NUM_CT];
  logic [BTC_NUM_CT-1:0] ct_run_reg;
  logic [BTC_NUM_CT-1:0] ct_done_reg;
  logic [BTC_NUM_CT-1:0] ct_out_reg;
  logic [BTC_NUM_CT-1:0] ct_x16_reg;
  logic [BTC_NUM_CT-1:0] ct_step;
  logic [BTC_NUM_CT-1:0] ct_expire;
  logic [BTC_NUM_CT-1:0] ct_hit;
  logic [BTC_NUM_CT-1:0] ct_ctl_wr;

  for (genvar k = 0; k < BTC_NUM_CT; k++) begin : g_ct
    localparam logic [7:0] A_LO = unit_adr(BTC_CT_BASE, k, BTC_OFS_LO);
    localparam logic [7:0] A_HI = unit_adr(BTC_CT_BASE, k, BTC_OFS_HI);
    localparam logic [7:0] A_CTL = unit_adr(BTC_CT_BASE, k, BTC_OFS_CTL);

    assign ct_ctl_wr[k] = bus_wr && wb_adr_i == A_CTL;
    // Character mode counts received characters, others count source
    assign ct_step[k] = (ct_mode_reg[k] == BTC_MODE_CHAR) ?
        rx_char_i[k] : src_tick(pre_reg, ct_src_reg[k]);
    assign ct_hit[k] = ct_run_reg[k] && ct_step[k] &&
        ct_cnt_reg[k] <= 16'h0001;
    // A control write in the expiry cycle defers the reload, not the flag
    assign ct_expire[k] = ct_hit[k] && !ct_ctl_wr[k];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ct_preset_reg[k] <= BTC_PRESET_RST;
      end else if (bus_wr && wb_adr_i == A_LO) begin
        ct_preset_reg[k][7:0] <= wb_dat_i[7:0];
      end else if (bus_wr && wb_adr_i == A_HI) begin
        ct_preset_reg[k][15:8] <= wb_dat_i[7:0];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ct_src_reg[k] <= BTC_SRC_RST;
        ct_mode_reg[k] <= BTC_MODE_TIMER;
        ct_run_reg[k] <= 1'b0;
      end else if (ct_ctl_wr[k]) begin
        ct_src_reg[k] <= wb_dat_i[BTC_SRC_LSB +: 3];
        ct_mode_reg[k] <= btc_mode_t'(wb_dat_i[BTC_MODE_LSB +: 2]);
        ct_run_reg[k] <= wb_dat_i[BTC_CT_RUN_BIT];
      end else if (ct_expire[k] && ct_mode_reg[k] != BTC_MODE_TIMER) begin
        ct_run_reg[k] <= 1'b0;
      end
    end

    // Start reloads from the preset; stop freezes the count
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ct_cnt_reg[k] <= BTC_PRESET_RST;
        ct_out_reg[k] <= 1'b0;
      end else if (ct_ctl_wr[k]) begin
        if (wb_dat_i[BTC_CT_RUN_BIT] && !ct_run_reg[k]) begin
          ct_cnt_reg[k] <= ct_preset_reg[k];
          ct_out_reg[k] <= 1'b0;
        end
      end else if (ct_run_reg[k]) begin
        if (ct_mode_reg[k] == BTC_MODE_TIMEOUT && rx_char_i[k]) begin
          ct_cnt_reg[k] <= ct_preset_reg[k];
        end else if (ct_expire[k]) begin
          ct_cnt_reg[k] <= ct_preset_reg[k];
          if (ct_mode_reg[k] == BTC_MODE_TIMER) begin
            ct_out_reg[k] <= ~ct_out_reg[k];
          end
        end else if (ct_step[k]) begin
          ct_cnt_reg[k] <= ct_cnt_reg[k] - 16'h0001;
        end
      end
    end

    // Expiry wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ct_done_reg[k] <= 1'b0;
      end else if (ct_hit[k] && ct_mode_reg[k] != BTC_MODE_TIMER) begin
        ct_done_reg[k] <= 1'b1;
      end else if (ct_ctl_wr[k] && wb_dat_i[BTC_CT_DONE_BIT]) begin
        ct_done_reg[k] <= 1'b0;
      end
    end

    // One 16x strobe per full output period
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ct_x16_reg[k] <= 1'b0;
        gp_ct_o[k] <= 1'b0;
      end else begin
        ct_x16_reg[k] <= ct_expire[k] &&
            (ct_mode_reg[k] != BTC_MODE_TIMER || !ct_out_reg[k]);
        gp_ct_o[k] <= (ct_mode_reg[k] == BTC_MODE_TIMER) ?
            ct_out_reg[k] : ct_done_reg[k];
      end
    end
  end

  // ---------------------------------------------------------------
  // Programmable rate dividers
  // ---------------------------------------------------------------
  logic [15:0] prd_preset_reg [BTC_NUM_PRD];
  logic [15:0] prd_cnt_reg [BTC_NUM_PRD];
  logic [2:0] prd_src_reg [BTC_NUM_PRD];
  logic [BTC_NUM_PRD-1:0] prd_run_reg;
  logic [BTC_NUM_PRD-1:0] prd_out_reg;
  logic [BTC_NUM_PRD-1:0] prd_x16_reg;
  logic [BTC_NUM_PRD-1:0] prd_step;

  for (genvar j = 0; j < BTC_NUM_PRD; j++) begin : g_prd
    localparam logic [7:0] A_LO = unit_adr(BTC_PRD_BASE, j, BTC_OFS_LO);
    localparam logic [7:0] A_HI = unit_adr(BTC_PRD_BASE, j, BTC_OFS_HI);
    localparam logic [7:0] A_CTL = unit_adr(BTC_PRD_BASE, j, BTC_OFS_CTL);

    assign prd_step[j] = prd_run_reg[j] &&
        src_tick(pre_reg, prd_src_reg[j]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prd_preset_reg[j] <= BTC_PRESET_RST;
        prd_src_reg[j] <= BTC_SRC_RST;
        prd_run_reg[j] <= 1'b0;
      end else if (bus_wr && wb_adr_i == A_LO) begin
        prd_preset_reg[j][7:0] <= wb_dat_i[7:0];
      end else if (bus_wr && wb_adr_i == A_HI) begin
        prd_preset_reg[j][15:8] <= wb_dat_i[7:0];
      end else if (bus_wr && wb_adr_i == A_CTL) begin
        prd_src_reg[j] <= wb_dat_i[BTC_SRC_LSB +: 3];
        prd_run_reg[j] <= wb_dat_i[BTC_PRD_RUN_BIT];
      end
    end

    // Each half period counts the preset down once
    always_ff @(posedge clk_i) begin
      if (rst_i || !prd_run_reg[j]) begin
        prd_cnt_reg[j] <= prd_preset_reg[j];
        prd_out_reg[j] <= 1'b0;
      end else if (prd_step[j]) begin
        if (prd_cnt_reg[j] <= 16'h0001) begin
          prd_cnt_reg[j] <= prd_preset_reg[j];
          prd_out_reg[j] <= ~prd_out_reg[j];
        end else begin
          prd_cnt_reg[j] <= prd_cnt_reg[j] - 16'h0001;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prd_x16_reg[j] <= 1'b0;
        gp_prd_o[j] <= 1'b0;
      end else begin
        prd_x16_reg[j] <= prd_step[j] && prd_cnt_reg[j] <= 16'h0001 &&
            !prd_out_reg[j];
        gp_prd_o[j] <= prd_out_reg[j];
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver and transmitter clock selection
  // ---------------------------------------------------------------
  // Entry 2c is receiver c, entry 2c+1 transmitter c
  logic [31:0] x16_pool;
  logic [BTC_SEL_W-1:0] csel_reg [2*NUM_CH];
  logic [3:0] phase_reg [2*NUM_CH];
  btc_sclk_t sclk_reg [2*NUM_CH];

  assign x16_pool = {1'b0, prd_x16_reg, ct_x16_reg, fixed_rate_x16_o};

  for (genvar s = 0; s < 2 * NUM_CH; s++) begin : g_sel
    localparam logic [7:0] A_SEL = BTC_CSEL_BASE + 8'(s) * BTC_CSEL_STRIDE;
    logic pick;
    logic sel_wr;
    assign sel_wr = bus_wr && wb_adr_i == A_SEL;
    assign pick = x16_pool[csel_reg[s]];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        csel_reg[s] <= BTC_SEL_OFF;
      end else if (sel_wr) begin
        csel_reg[s] <= wb_dat_i[BTC_SEL_W-1:0];
      end
    end

    // Restart the bit phase when the source changes
    always_ff @(posedge clk_i) begin
      if (rst_i || sel_wr) begin
        phase_reg[s] <= 4'h0;
        sclk_reg[s] <= '0;
      end else begin
        if (pick) begin
          phase_reg[s] <= phase_reg[s] + 4'h1;
        end
        sclk_reg[s].x16 <= pick;
        sclk_reg[s].mid <= pick && phase_reg[s] == BTC_MID_PHASE;
        sclk_reg[s].bit_end <= pick &&
            phase_reg[s] == BTC_LAST_PHASE;
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_out
    assign rx_sclk_o[c] = sclk_reg[2*c];
    assign tx_sclk_o[c] = sclk_reg[2*c+1];
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Counter/timer data reads show the live count, divider reads the preset
  always_comb begin
    rd_next = 32'h0000_0000;
    for (int k = 0; k < BTC_NUM_CT; k++) begin
      if (wb_adr_i == unit_adr(BTC_CT_BASE, k, BTC_OFS_LO)) begin
        rd_next[7:0] = ct_cnt_reg[k][7:0];
      end
      if (wb_adr_i == unit_adr(BTC_CT_BASE, k, BTC_OFS_HI)) begin
        rd_next[7:0] = ct_cnt_reg[k][15:8];
      end
      if (wb_adr_i == unit_adr(BTC_CT_BASE, k, BTC_OFS_CTL)) begin
        rd_next[BTC_SRC_LSB +: 3] = ct_src_reg[k];
        rd_next[BTC_MODE_LSB +: 2] = ct_mode_reg[k];
        rd_next[BTC_CT_RUN_BIT] = ct_run_reg[k];
        rd_next[BTC_CT_DONE_BIT] = ct_done_reg[k];
      end
    end
    for (int j = 0; j < BTC_NUM_PRD; j++) begin
      if (wb_adr_i == unit_adr(BTC_PRD_BASE, j, BTC_OFS_LO)) begin
        rd_next[7:0] = prd_preset_reg[j][7:0];
      end
      if (wb_adr_i == unit_adr(BTC_PRD_BASE, j, BTC_OFS_HI)) begin
        rd_next[7:0] = prd_preset_reg[j][15:8];
      end
      if (wb_adr_i == unit_adr(BTC_PRD_BASE, j, BTC_OFS_CTL)) begin
        rd_next[BTC_SRC_LSB +: 3] = prd_src_reg[j];
        rd_next[BTC_PRD_RUN_BIT] = prd_run_reg[j];
      end
    end
    for (int s = 0; s < 2 * NUM_CH; s++) begin
      if (wb_adr_i == BTC_CSEL_BASE + 8'(s) * BTC_CSEL_STRIDE) begin
        rd_next[BTC_SEL_W-1:0] = csel_reg[s];
      end
    end
  end

  // Unmapped addresses still ack, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_next : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [3:0] a_x16_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_sclk_o[0].bit_end || g_sel[0].sel_wr ||
        csel_reg[0] == BTC_SEL_OFF) begin
      a_x16_seen <= 4'h0;
    end else if (rx_sclk_o[0].x16) begin
      a_x16_seen <= a_x16_seen + 4'h1;
    end
  end

  sequence s_every_other;
    !fixed_rate_x16_o[1] ##1 fixed_rate_x16_o[1];
  endsequence
  sequence s_every_fourth;
    !fixed_rate_x16_o[2] [*3] ##1 fixed_rate_x16_o[2];
  endsequence

  property p_rate_half;
    @(posedge clk_i) disable iff (rst_i)
      fixed_rate_x16_o[1] |=> s_every_other;
  endproperty
  a_rate_half: assert property (p_rate_half)
    else $error("Second fixed rate not every other cycle");

  property p_rate_quarter;
    @(posedge clk_i) disable iff (rst_i)
      fixed_rate_x16_o[2] |=> s_every_fourth;
  endproperty
  a_rate_quarter: assert property (p_rate_quarter)
    else $error("Third fixed rate not every fourth cycle");

  property p_bit_sixteen;
    @(posedge clk_i) disable iff (rst_i)
      rx_sclk_o[0].bit_end |-> a_x16_seen == 4'hf;
  endproperty
  a_bit_sixteen: assert property (p_bit_sixteen)
    else $error("Bit end not after sixteen strobes");

  property p_ct_reload;
    @(posedge clk_i) disable iff (rst_i)
      ct_expire[0] && !(ct_mode_reg[0] == BTC_MODE_TIMEOUT && rx_char_i[0])
      |=> ct_cnt_reg[0] == $past(ct_preset_reg[0]);
  endproperty
  a_ct_reload: assert property (p_ct_reload)
    else $error("Counter/timer did not reload preset");

  property p_ct_div_one;
    @(posedge clk_i) disable iff (rst_i)
      ct_expire[0] && ct_mode_reg[0] == BTC_MODE_TIMER
      |=> ct_out_reg[0] != $past(ct_out_reg[0]);
  endproperty
  a_ct_div_one: assert property (p_ct_div_one)
    else $error("Timer output did not toggle at expiry");

  property p_prd_count;
    @(posedge clk_i) disable iff (rst_i)
      prd_step[0] && prd_cnt_reg[0] > 16'h0001 && prd_run_reg[0]
      |=> prd_cnt_reg[0] == $past(prd_cnt_reg[0]) - 16'h0001
          && $stable(prd_out_reg[0]);
  endproperty
  a_prd_count: assert property (p_prd_count)
    else $error("Divider half period broken");

  property p_preset_low;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && wb_adr_i == BTC_CT_BASE + BTC_OFS_LO
      |=> ct_preset_reg[0][7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_preset_low: assert property (p_preset_low)
    else $error("Low preset byte not written");

  property p_ct_stop;
    @(posedge clk_i) disable iff (rst_i)
      !ct_run_reg[0] && !ct_ctl_wr[0] |=> $stable(ct_cnt_reg[0]);
  endproperty
  a_ct_stop: assert property (p_ct_stop)
    else $error("Stopped counter/timer moved");

  // Last receiver, so the check fits every channel count
  localparam int A_LAST_RX = 2 * (NUM_CH - 1);
  property p_sel_ct;
    @(posedge clk_i) disable iff (rst_i)
      csel_reg[A_LAST_RX] == BTC_SEL_CT0 && ct_x16_reg[0] &&
      !g_sel[A_LAST_RX].sel_wr
      |=> rx_sclk_o[NUM_CH-1].x16;
  endproperty
  a_sel_ct: assert property (p_sel_ct)
    else $error("Selected timer strobe not passed on");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Bus ack not a single cycle");

endmodule

/* File: tb/btc_serial_partner.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Serial channel consumer: divides its 16x clock by 16
// ---------------------------------------------------------------
module btc_serial_partner
  import btc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire btc_sclk_t sclk_i,
  output int bad_o,
  output int bits_o
);
  int phase_reg;
  // Phase counts from reset, so only a channel selected once
  // keeps step with the block's own phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 0;
      bad_o <= 0;
      bits_o <= 0;
    end else if (sclk_i.x16) begin
      phase_reg <= (phase_reg == 15) ? 0 : phase_reg + 1;
      if (sclk_i.bit_end !== (phase_reg == 15)) bad_o <= bad_o + 1;
      if (sclk_i.mid !== (phase_reg == 7)) bad_o <= bad_o + 1;
      if (sclk_i.bit_end) bits_o <= bits_o + 1;
    end else if (sclk_i.mid || sclk_i.bit_end) begin
      bad_o <= bad_o + 1;
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  import btc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic [3:0] sel = 4'h0;
  logic [1:0] rx_char = 2'h0, gp_ct, gp_prd;
  logic wb_ack_o;
  logic [BTC_NUM_RATES-1:0] fixed;
  btc_sclk_t [1:0] rx_s, tx_s;
  logic [15:0] lfsr = 16'hb82f;
  int err_count = 0, n_checks = 0, cycles = 0, p, g, bad0, bad1, nb0, nb1;
  int rate_idx[4] = '{0, 5, 14, 26};
  int rate_per[4] = '{1, 24, 461, 18432};

  btc_clock_gen #(.NUM_CH(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_char_i(rx_char), .fixed_rate_x16_o(fixed),
    .gp_ct_o(gp_ct), .gp_prd_o(gp_prd), .rx_sclk_o(rx_s), .tx_sclk_o(tx_s));
  btc_serial_partner rx0 (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(rx_s[0]),
    .bad_o(bad0), .bits_o(nb0));
  btc_serial_partner tx0 (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(tx_s[0]),
    .bad_o(bad1), .bits_o(nb1));

  initial forever #2 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Long fixed rate dominates the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout %h %h", $time, cycles, 0);
      finish_test();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00, 4'h0);
    chk_val(q, exp);
  endtask

  function automatic logic get(input int w);
    if (w < 2) return gp_prd[w];
    if (w < 4) return gp_ct[w-2];
    if (w == 40) return rx_s[0].x16;
    if (w == 41) return tx_s[0].x16;
    if (w == 42) return rx_s[1].x16;
    if (w == 43) return tx_s[1].x16;
    return fixed[w-4];
  endfunction

  function automatic bit ev(input int w, input bit sq, input logic v);
    return sq ? (get(w) !== v) : (get(w) === 1'b1);
  endfunction

  // Strobes: cycles between pulses; squares: cycles between changes
  task automatic gap(input int w, input bit sq, output int n);
    logic v;
    @(negedge clk_i);
    v = get(w);
    do @(negedge clk_i); while (!ev(w, sq, v));
    v = get(w);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!ev(w, sq, v));
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_char[k] <= 1'b1;
      @(posedge clk_i);
      rx_char[k] <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h20, 32'h1);
    rd(8'h40, 32'h1f);
    wr(8'h80, 8'hff);
    rd(8'h80, 32'h0);
    $display("test reset done");
    foreach (rate_idx[i]) begin
      gap(4 + rate_idx[i], 1'b0, g);
      chk_cyc(g, rate_per[i]);
    end
    $display("test fixed rates done");
    lfsr = nxt(lfsr);
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 1 : (i == 1) ? 2 + lfsr % 14 : 16'h0102;
      wr(8'h20, p[7:0]);
      wr(8'h24, p[15:8]);
      wr(8'h28, 8'h08);
      gap(0, 1'b1, g);
      chk_cyc(g, p);
      rd(8'h24, {24'h0, p[15:8]});
      wr(8'h28, 8'h00);
    end
    wb(1'b1, 8'h20, 8'h55, 4'h0);
    rd(8'h20, 32'h02);
    wr(8'h20, 8'h03);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h08);
    wr(8'h40, 8'h1d);
    wr(8'h44, 8'h01);
    gap(40, 1'b0, g);
    chk_cyc(g, 6);
    gap(41, 1'b0, g);
    chk_cyc(g, 2);
    wr(8'h20, 8'h05);
    gap(0, 1'b1, g);
    chk_cyc(g, 5);
    wr(8'h30, 8'h02);
    wr(8'h38, 8'h0a);
    gap(1, 1'b1, g);
    chk_cyc(g, 8);
    wr(8'h4c, 8'h1e);
    gap(43, 1'b0, g);
    chk_cyc(g, 16);
    repeat (600) @(posedge clk_i);
    chk_cyc(bad0 + bad1, 0);
    chk_cyc(int'(nb0 >= 3 && nb1 >= 8), 1);
    $display("test dividers done");
    lfsr = nxt(lfsr);
    p = 1 + lfsr % 9;
    wr(8'h00, p[7:0]);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h31);
    gap(2, 1'b1, g);
    chk_cyc(g, 2 * p);
    wr(8'h48, 8'h1b);
    gap(42, 1'b0, g);
    chk_cyc(g, 4 * p);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h05);
    wr(8'h08, 8'h28);
    repeat (20) @(posedge clk_i);
    rd(8'h08, 32'h48);
    chk_val({31'h0, gp_ct[0]}, 32'h1);
    wr(8'h10, 8'h03);
    wr(8'h18, 8'h20);
    pulse(1, 2);
    rd(8'h18, 32'h20);
    pulse(1, 1);
    rd(8'h18, 32'h40);
    wr(8'h18, 8'h40);
    wr(8'h10, 8'h0a);
    wr(8'h18, 8'h38);
    pulse(1, 8);
    rd(8'h18, 32'h38);
    repeat (20) @(posedge clk_i);
    rd(8'h18, 32'h58);
    chk_val({31'h0, gp_ct[1]}, 32'h1);
    $display("test counter modes done");
    finish_test();
  end
endmodule
